/* design/pdc_top.sv */
`timescale 1ns/1ps
module pdc_top #(
  parameter int NUM_CH = pdc_pkg::NUM_CH,
  parameter int NUM_REQ = pdc_pkg::NUM_REQ,
  parameter int NUM_IRQ = pdc_pkg::NUM_IRQ,
  parameter int FIFO_DEPTH = pdc_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Register bus.
  input wire pdc_pkg::pdc_apb_req_s apb_req,
  output pdc_pkg::pdc_apb_rsp_s apb_rsp,
  // Peripheral request levels.
  input wire logic [NUM_REQ-1:0] periph_req,
  // Interrupts and abort.
  output logic [NUM_IRQ-1:0] irq,
  output logic abort
);
  localparam int BW = $clog2(FIFO_DEPTH + 1);
  localparam int CW = $clog2(NUM_CH);
  localparam int EW = $clog2(NUM_IRQ);

  typedef struct packed {
    logic [NUM_CH-1:0][31:0] sar;
    logic [NUM_CH-1:0][31:0] dar;
    logic [NUM_CH-1:0][31:0] ccr;
    pdc_pkg::pdc_thr_e [NUM_CH-1:0] cst;
    logic [NUM_CH-1:0][pdc_pkg::WAIT_W-1:0] cwait;
    pdc_pkg::pdc_thr_e mst;
    logic [pdc_pkg::WAIT_W-1:0] mwait;
    logic [NUM_IRQ-1:0] interrupt_enable_mask;
    logic [NUM_IRQ-1:0] irq;
    logic [NUM_IRQ-1:0] evt;
    logic [NUM_CH-1:0] fsrc;
    logic [NUM_CH-1:0][3:0] ftr;
    logic fsrd;
    logic [3:0] ftrd;
    logic [31:0] insn_lo;
    logic [31:0] insn_hi;
    logic [BW-1:0] buf_used;
    logic [NUM_CH-1:0] split;
    logic [NUM_REQ-1:0] req_s1;
    logic [NUM_REQ-1:0] req_s2;
    logic ack;
    logic slverr;
    logic [31:0] prdata;
  } pdc_state_s;

  pdc_state_s s_r;
  pdc_state_s s_nxt;
  pdc_pkg::pdc_dec_s dec;
  logic access;
  logic wr_en;
  logic issue;
  logic is_mgr;
  logic [CW-1:0] ch;
  logic [NUM_IRQ-1:0] clr_vec;

  pdc_decode u_decode (
    .insn (s_r.insn_lo),
    .dec (dec)
  );

  function automatic logic [2:0] size_of(input logic [31:0] ccr);
    size_of = ccr[pdc_pkg::CCR_SIZE_LSB +: 3];
  endfunction

  // A beat splits when the lane offset is not a multiple of the beat size.
  function automatic logic split_of(input logic [31:0] sa, input logic [31:0] da,
                                    input logic [31:0] ccr);
    logic [pdc_pkg::LANE_BITS-1:0] ofs;
    logic [pdc_pkg::LANE_BITS-1:0] msk;
    ofs = da[pdc_pkg::LANE_BITS-1:0] - sa[pdc_pkg::LANE_BITS-1:0];
    msk = pdc_pkg::LANE_BITS'((1 << size_of(ccr)) - 1);
    // Aligned offsets leave every beat whole.
    split_of = |(ofs & msk);
  endfunction

  function automatic logic [31:0] xfer_bytes(input logic [31:0] ccr);
    logic [8:0] beats;
    beats = 9'(ccr[pdc_pkg::CCR_BURST_LSB +: 4]) + 9'd1;
    xfer_bytes = 32'(beats << size_of(ccr));
  endfunction

  assign access = apb_req.psel && apb_req.penable;
  assign wr_en = access && s_r.ack && apb_req.pwrite;
  assign issue = wr_en && (apb_req.paddr == pdc_pkg::OFS_ISSUE);
  assign is_mgr = apb_req.pwdata[3:0] == pdc_pkg::MGR_SEL;
  assign ch = apb_req.pwdata[CW-1:0];
  assign clr_vec = (wr_en && apb_req.paddr == pdc_pkg::OFS_INTERRUPT_CLEAR_CONTROL) ?
                   apb_req.pwdata[NUM_IRQ-1:0] : '0;

  always_comb begin
    logic [31:0] opnd;
    logic [BW-1:0] need;
    logic [CW-1:0] tgt;
    logic [CW-1:0] rch;
    logic [EW-1:0] en;
    s_nxt = s_r;
    opnd = '0;
    need = '0;
    tgt = '0;
    rch = '0;
    en = '0;
    // Request levels pass two flops before any logic looks at them.
    s_nxt.req_s1 = periph_req;
    s_nxt.req_s2 = s_r.req_s1;

    for (int i = 0; i < NUM_CH; i++) begin
      if (s_r.cst[i] == pdc_pkg::thr_wait_event && s_r.evt[s_r.cwait[i][EW-1:0]]) begin
        s_nxt.cst[i] = pdc_pkg::thr_executing;
        s_nxt.evt[s_r.cwait[i][EW-1:0]] = 1'b0;
      end
      // A high level on the awaited line releases the channel.
      if (s_r.cst[i] == pdc_pkg::thr_wait_periph && s_r.req_s2[s_r.cwait[i]]) begin
        s_nxt.cst[i] = pdc_pkg::thr_executing;
      end
    end
    if (s_r.mst == pdc_pkg::thr_wait_event && s_r.evt[s_r.mwait[EW-1:0]]) begin
      s_nxt.mst = pdc_pkg::thr_executing;
      s_nxt.evt[s_r.mwait[EW-1:0]] = 1'b0;
    end

    // Bus slave: one wait state, read data captured in the first access cycle.
    s_nxt.ack = access && !s_r.ack;
    if (access && !s_r.ack) begin
      s_nxt.prdata = '0;
      s_nxt.slverr = 1'b0;
      rch = apb_req.paddr[5 +: CW];
      unique case (apb_req.paddr)
        pdc_pkg::OFS_DSR: s_nxt.prdata = 32'(s_r.mst);
        pdc_pkg::OFS_INTERRUPT_ENABLE_MASK: s_nxt.prdata = 32'(s_r.interrupt_enable_mask);
        // Raw status merges events and interrupts; no channel is recorded.
        pdc_pkg::OFS_EVENT_RIS: s_nxt.prdata = 32'(s_r.evt | s_r.irq);
        pdc_pkg::OFS_INTMIS: s_nxt.prdata = 32'(s_r.irq);
        pdc_pkg::OFS_FSRD: s_nxt.prdata = 32'(s_r.fsrd);
        pdc_pkg::OFS_FSRC: s_nxt.prdata = 32'(s_r.fsrc);
        pdc_pkg::OFS_FTRD: s_nxt.prdata = 32'(s_r.ftrd);
        pdc_pkg::OFS_INSN_LO: s_nxt.prdata = s_r.insn_lo;
        pdc_pkg::OFS_INSN_HI: s_nxt.prdata = s_r.insn_hi;
        pdc_pkg::OFS_INTERRUPT_CLEAR_CONTROL, pdc_pkg::OFS_ISSUE: s_nxt.prdata = '0;
        default: begin
          if (apb_req.paddr[11:5] == pdc_pkg::FTR_PAGE) begin
            s_nxt.prdata = 32'(s_r.ftr[apb_req.paddr[2 +: CW]]);
          end else if (apb_req.paddr[11:8] == pdc_pkg::CSR_PAGE && !apb_req.paddr[2]) begin
            s_nxt.prdata = {26'h000_0000, s_r.split[apb_req.paddr[3 +: CW]],
                            2'b00, s_r.cst[apb_req.paddr[3 +: CW]]};
          end else if (apb_req.paddr[11:8] == pdc_pkg::CH_PAGE &&
                       apb_req.paddr[4:0] == pdc_pkg::CH_SAR) begin
            s_nxt.prdata = s_r.sar[rch];
          end else if (apb_req.paddr[11:8] == pdc_pkg::CH_PAGE &&
                       apb_req.paddr[4:0] == pdc_pkg::CH_DAR) begin
            s_nxt.prdata = s_r.dar[rch];
          end else if (apb_req.paddr[11:8] == pdc_pkg::CH_PAGE &&
                       apb_req.paddr[4:0] == pdc_pkg::CH_CCR) begin
            s_nxt.prdata = s_r.ccr[rch];
          end else if (!(apb_req.paddr[11:8] == pdc_pkg::CSR_PAGE)) begin
            s_nxt.slverr = 1'b1;
          end
        end
      endcase
    end

    if (wr_en && apb_req.paddr == pdc_pkg::OFS_INTERRUPT_ENABLE_MASK) begin
      s_nxt.interrupt_enable_mask = apb_req.pwdata[NUM_IRQ-1:0];
    end
    if (wr_en && apb_req.paddr == pdc_pkg::OFS_INSN_LO) s_nxt.insn_lo = apb_req.pwdata;
    if (wr_en && apb_req.paddr == pdc_pkg::OFS_INSN_HI) s_nxt.insn_hi = apb_req.pwdata;
    if (wr_en && apb_req.paddr == pdc_pkg::OFS_FSRD && apb_req.pwdata[0]) begin
      s_nxt.fsrd = 1'b0;
      s_nxt.ftrd = '0;
      s_nxt.mst = pdc_pkg::thr_stopped;
    end
    // Only enabled interrupts fall; a same-cycle raise below still wins.
    s_nxt.irq = s_nxt.irq & ~(clr_vec & s_r.interrupt_enable_mask);

    en = dec.arg8[EW-1:0];
    if (issue && is_mgr &&
        (s_r.mst == pdc_pkg::thr_stopped || s_r.mst == pdc_pkg::thr_executing)) begin
      s_nxt.mst = pdc_pkg::thr_executing;
      if (!dec.mgr_ok) begin
        // Channel-only code in the manager faults the manager.
        s_nxt.mst = pdc_pkg::thr_faulting;
        s_nxt.fsrd = 1'b1;
        s_nxt.ftrd[pdc_pkg::FT_UNDEF] = 1'b1;
      end else begin
        unique case (dec.op)
          pdc_pkg::launch_channel_op: begin
            tgt = dec.arg8[CW-1:0];
            if (s_r.cst[tgt] == pdc_pkg::thr_stopped) s_nxt.cst[tgt] = pdc_pkg::thr_executing;
          end
          // Enabled resources latch their interrupt high.
          pdc_pkg::send_event_op: begin
            if (s_r.interrupt_enable_mask[en]) s_nxt.irq[en] = 1'b1;
            else s_nxt.evt[en] = 1'b1;
          end
          pdc_pkg::wait_event_op: begin
            s_nxt.mst = pdc_pkg::thr_wait_event;
            s_nxt.mwait = dec.arg8[pdc_pkg::WAIT_W-1:0];
          end
          pdc_pkg::end_thread_op: s_nxt.mst = pdc_pkg::thr_stopped;
          default: s_nxt.mst = pdc_pkg::thr_executing;
        endcase
      end
    end

    // Each of the eight channels keeps its own state and is issued independently.
    if (issue && !is_mgr && !apb_req.pwdata[3] && s_r.cst[ch] == pdc_pkg::thr_executing) begin
      need = split_of(s_r.sar[ch], s_r.dar[ch], s_r.ccr[ch]) ? BW'(2) : BW'(1);
      if (!dec.ch_ok) begin
        // Launch is refused in a channel thread.
        s_nxt.cst[ch] = pdc_pkg::thr_faulting;
        s_nxt.fsrc[ch] = 1'b1;
        s_nxt.ftr[ch][pdc_pkg::FT_UNDEF] = 1'b1;
      end else begin
        unique case (dec.op)
          pdc_pkg::add_halfword_op, pdc_pkg::add_negative_halfword_op: begin
            // Ones fill the upper half for the negative form.
            opnd = (dec.op == pdc_pkg::add_negative_halfword_op) ?
                   {pdc_pkg::ONES16, dec.imm16} : {16'h0000, dec.imm16};
            // Carry is dropped; select picks source or destination.
            if (dec.ra) s_nxt.dar[ch] = 32'(s_r.dar[ch] + opnd);
            else s_nxt.sar[ch] = 32'(s_r.sar[ch] + opnd);
          end
          pdc_pkg::move_register_op: begin
            if (dec.arg8 == pdc_pkg::MOV_SAR) s_nxt.sar[ch] = s_r.insn_hi;
            if (dec.arg8 == pdc_pkg::MOV_DAR) s_nxt.dar[ch] = s_r.insn_hi;
            if (dec.arg8 == pdc_pkg::MOV_CCR) begin
              // Secure or oversized settings fault, register kept.
              if (s_r.insn_hi[pdc_pkg::CCR_SRC_SEC_BIT] || s_r.insn_hi[pdc_pkg::CCR_DST_SEC_BIT] ||
                  size_of(s_r.insn_hi) > 3'(pdc_pkg::MAX_SIZE_LOG2)) begin
                s_nxt.cst[ch] = pdc_pkg::thr_faulting;
                s_nxt.fsrc[ch] = 1'b1;
                s_nxt.ftr[ch][pdc_pkg::FT_RDWR] = 1'b1;
              end else begin
                s_nxt.ccr[ch] = s_r.insn_hi;
              end
            end
          end
          pdc_pkg::load_op: begin
            // Split beats reserve both lines in one step.
            // With no gap between the two halves, a channel 0 update cannot
            // land between them, so the pair is never torn.
            if (32'(s_r.buf_used) + 32'(need) <= 32'(FIFO_DEPTH)) begin
              s_nxt.buf_used = BW'(s_r.buf_used + need);
              s_nxt.split[ch] = need == BW'(2);
              s_nxt.sar[ch] = 32'(s_r.sar[ch] + xfer_bytes(s_r.ccr[ch]));
            end
          end
          pdc_pkg::store_op: begin
            s_nxt.buf_used = (s_r.buf_used > need) ? BW'(s_r.buf_used - need) : '0;
            s_nxt.dar[ch] = 32'(s_r.dar[ch] + xfer_bytes(s_r.ccr[ch]));
          end
          pdc_pkg::send_event_op: begin
            if (s_r.interrupt_enable_mask[en]) s_nxt.irq[en] = 1'b1;
            else s_nxt.evt[en] = 1'b1;
          end
          pdc_pkg::wait_event_op: begin
            s_nxt.cst[ch] = pdc_pkg::thr_wait_event;
            s_nxt.cwait[ch] = dec.arg8[pdc_pkg::WAIT_W-1:0];
          end
          pdc_pkg::wait_peripheral_op: begin
            // Only the twenty mapped lines can be awaited.
            if (32'(dec.arg8) < 32'(NUM_REQ)) begin
              s_nxt.cst[ch] = pdc_pkg::thr_wait_periph;
              s_nxt.cwait[ch] = dec.arg8[pdc_pkg::WAIT_W-1:0];
            end else begin
              s_nxt.cst[ch] = pdc_pkg::thr_faulting;
              s_nxt.fsrc[ch] = 1'b1;
              s_nxt.ftr[ch][pdc_pkg::FT_PERIPH] = 1'b1;
            end
          end
          pdc_pkg::end_thread_op: s_nxt.cst[ch] = pdc_pkg::thr_stopped;
          default: s_nxt.cst[ch] = pdc_pkg::thr_executing;
        endcase
      end
    end
    if (issue && !is_mgr && !apb_req.pwdata[3] && dec.op == pdc_pkg::terminate_thread_op &&
        s_r.cst[ch] != pdc_pkg::thr_stopped) begin
      s_nxt.cst[ch] = pdc_pkg::thr_stopped;
      s_nxt.fsrc[ch] = 1'b0;
      s_nxt.ftr[ch] = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Sixteen level interrupts and one abort.
  assign irq = s_r.irq;
  assign abort = (|s_r.fsrc) || s_r.fsrd;
  assign apb_rsp.pready = s_r.ack;
  assign apb_rsp.pslverr = s_r.ack && s_r.slverr;
  assign apb_rsp.prdata = s_r.prdata;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_adnh_src_add: assert property (
    issue && !is_mgr && !apb_req.pwdata[3] && s_r.cst[ch] == pdc_pkg::thr_executing &&
    dec.op == pdc_pkg::add_negative_halfword_op && !dec.ra
    |=> s_r.sar[$past(ch)] == 32'($past(s_r.sar[ch]) + {16'hFFFF, $past(dec.imm16)}))
    else $error("negative halfword add result wrong");

  a_adnh_dst_sel: assert property (
    issue && !is_mgr && !apb_req.pwdata[3] && s_r.cst[ch] == pdc_pkg::thr_executing &&
    dec.op == pdc_pkg::add_negative_halfword_op && dec.ra
    |=> s_r.sar[$past(ch)] == $past(s_r.sar[ch]))
    else $error("destination select touched source address");

  a_mgr_reject: assert property (
    issue && is_mgr && s_r.mst == pdc_pkg::thr_executing && !dec.mgr_ok
    |=> s_r.mst == pdc_pkg::thr_faulting && s_r.fsrd && abort)
    else $error("manager ran a channel-only instruction");

  a_sev_raise: assert property (
    issue && is_mgr &&
    (s_r.mst == pdc_pkg::thr_stopped || s_r.mst == pdc_pkg::thr_executing) &&
    dec.op == pdc_pkg::send_event_op && s_r.interrupt_enable_mask[dec.arg8[EW-1:0]]
    |=> irq[$past(dec.arg8[EW-1:0])] ##1 irq[$past(dec.arg8[EW-1:0], 2)])
    else $error("enabled send event did not raise interrupt");

  a_irq_hold: assert property (
    ##1 (($past(s_r.irq) & ~$past(clr_vec & s_r.interrupt_enable_mask) & ~s_r.irq) == '0))
    else $error("interrupt fell without a clear");

  a_clr_drop: assert property (
    ((clr_vec & s_r.interrupt_enable_mask) != '0) && !issue
    |=> ((s_r.irq & $past(clr_vec & s_r.interrupt_enable_mask)) == '0))
    else $error("enabled clear left interrupt high");

  a_buf_limit: assert property (
    32'(s_r.buf_used) <= 32'(FIFO_DEPTH))
    else $error("shared buffer overfilled");

  a_secure_fault: assert property (
    issue && !is_mgr && !apb_req.pwdata[3] && s_r.cst[ch] == pdc_pkg::thr_executing &&
    dec.op == pdc_pkg::move_register_op && dec.arg8 == pdc_pkg::MOV_CCR &&
    (s_r.insn_hi[pdc_pkg::CCR_SRC_SEC_BIT] || s_r.insn_hi[pdc_pkg::CCR_DST_SEC_BIT])
    |=> s_r.cst[$past(ch)] == pdc_pkg::thr_faulting && s_r.ftr[$past(ch)][pdc_pkg::FT_RDWR])
    else $error("secure request did not fault");

  a_split_none: assert property (
    issue && !is_mgr && !apb_req.pwdata[3] && dec.op == pdc_pkg::load_op &&
    s_r.cst[ch] == pdc_pkg::thr_executing &&
    s_r.sar[ch][pdc_pkg::LANE_BITS-1:0] == s_r.dar[ch][pdc_pkg::LANE_BITS-1:0]
    |=> !s_r.split[$past(ch)])
    else $error("aligned beat was split");

  a_apb_ready: assert property (
    access && !s_r.ack |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("bus answer not one wait state");
endmodule

/* design/pdc_pkg.sv */
package pdc_pkg;
  localparam int NUM_CH = 8;
  localparam int NUM_REQ = 20;
  localparam int NUM_IRQ = 16;
  localparam int FIFO_DEPTH = 64;
  localparam int MAX_SIZE_LOG2 = 3;
  localparam int LANE_BITS = 4;
  localparam int WAIT_W = 5;
  localparam int ADDR_W = 12;

  localparam logic [7:0] ENC_END = 8'h00;
  localparam logic [7:0] ENC_KILL = 8'h01;
  localparam logic [7:0] ENC_LD = 8'h04;
  localparam logic [7:0] ENC_ST = 8'h08;
  localparam logic [7:0] ENC_NOP = 8'h18;
  localparam logic [7:0] ENC_WFP = 8'h30;
  localparam logic [7:0] ENC_SEV = 8'h34;
  localparam logic [7:0] ENC_FLUSHP = 8'h35;
  localparam logic [7:0] ENC_WFE = 8'h36;
  localparam logic [7:0] ENC_ADDH = 8'h54;
  localparam logic [7:0] ENC_ADNH = 8'h5C;
  localparam logic [7:0] ENC_ADD_MASK = 8'hFD;
  localparam logic [7:0] ENC_GO = 8'hA0;
  localparam logic [7:0] ENC_MOV = 8'hBC;
  localparam int ADNH_RA_BIT = 1;
  localparam logic [15:0] ONES16 = 16'hFFFF;
  localparam logic [7:0] MOV_SAR = 8'h00;
  localparam logic [7:0] MOV_CCR = 8'h01;
  localparam logic [7:0] MOV_DAR = 8'h02;

  localparam int CCR_SIZE_LSB = 1;
  localparam int CCR_BURST_LSB = 4;
  localparam int CCR_SRC_SEC_BIT = 8;
  localparam int CCR_DST_SEC_BIT = 22;
  localparam logic [3:0] MGR_SEL = 4'h8;

  localparam int FT_UNDEF = 0;
  localparam int FT_EVNT = 1;
  localparam int FT_RDWR = 2;
  localparam int FT_PERIPH = 3;

  localparam logic [ADDR_W-1:0] OFS_DSR = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_INTERRUPT_ENABLE_MASK = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_EVENT_RIS = 12'h024;
  localparam logic [ADDR_W-1:0] OFS_INTMIS = 12'h028;
  localparam logic [ADDR_W-1:0] OFS_INTERRUPT_CLEAR_CONTROL = 12'h02C;
  localparam logic [ADDR_W-1:0] OFS_FSRD = 12'h030;
  localparam logic [ADDR_W-1:0] OFS_FSRC = 12'h034;
  localparam logic [ADDR_W-1:0] OFS_FTRD = 12'h038;
  localparam logic [ADDR_W-1:0] OFS_ISSUE = 12'hD04;
  localparam logic [ADDR_W-1:0] OFS_INSN_LO = 12'hD08;
  localparam logic [ADDR_W-1:0] OFS_INSN_HI = 12'hD0C;
  localparam logic [6:0] FTR_PAGE = 7'h02;
  localparam logic [3:0] CSR_PAGE = 4'h1;
  localparam logic [3:0] CH_PAGE = 4'h4;
  localparam logic [4:0] CH_SAR = 5'h00;
  localparam logic [4:0] CH_DAR = 5'h04;
  localparam logic [4:0] CH_CCR = 5'h08;

  typedef enum logic [2:0] {
    thr_stopped, thr_executing, thr_wait_event, thr_wait_periph, thr_faulting
  } pdc_thr_e;

  typedef enum logic [3:0] {
    end_thread_op, terminate_thread_op, load_op, store_op, no_operation_op,
    wait_peripheral_op, send_event_op, flush_peripheral_op, wait_event_op,
    add_halfword_op, add_negative_halfword_op, launch_channel_op,
    move_register_op, undefined_op
  } pdc_op_e;

  typedef struct packed {
    pdc_op_e op;
    logic ra;
    logic [7:0] arg8;
    logic [15:0] imm16;
    logic mgr_ok;
    logic ch_ok;
  } pdc_dec_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } pdc_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pdc_apb_rsp_s;
endpackage

/* design/pdc_decode.sv */
`timescale 1ns/1ps
module pdc_decode (
  // Instruction bytes, first byte lowest.
  input wire logic [31:0] insn,
  // Decoded instruction.
  output pdc_pkg::pdc_dec_s dec
);
  function automatic pdc_pkg::pdc_op_e op_of(input logic [7:0] b);
    op_of = pdc_pkg::undefined_op;
    if (b == pdc_pkg::ENC_END) op_of = pdc_pkg::end_thread_op;
    if (b == pdc_pkg::ENC_KILL) op_of = pdc_pkg::terminate_thread_op;
    if (b == pdc_pkg::ENC_LD) op_of = pdc_pkg::load_op;
    if (b == pdc_pkg::ENC_ST) op_of = pdc_pkg::store_op;
    if (b == pdc_pkg::ENC_NOP) op_of = pdc_pkg::no_operation_op;
    if (b == pdc_pkg::ENC_WFP) op_of = pdc_pkg::wait_peripheral_op;
    if (b == pdc_pkg::ENC_SEV) op_of = pdc_pkg::send_event_op;
    if (b == pdc_pkg::ENC_FLUSHP) op_of = pdc_pkg::flush_peripheral_op;
    if (b == pdc_pkg::ENC_WFE) op_of = pdc_pkg::wait_event_op;
    if (b == pdc_pkg::ENC_GO) op_of = pdc_pkg::launch_channel_op;
    if (b == pdc_pkg::ENC_MOV) op_of = pdc_pkg::move_register_op;
    if ((b & pdc_pkg::ENC_ADD_MASK) == pdc_pkg::ENC_ADDH) op_of = pdc_pkg::add_halfword_op;
    // Opcode pattern with select bit masked out.
    if ((b & pdc_pkg::ENC_ADD_MASK) == pdc_pkg::ENC_ADNH) begin
      op_of = pdc_pkg::add_negative_halfword_op;
    end
  endfunction

  always_comb begin
    dec.op = op_of(insn[7:0]);
    dec.ra = insn[pdc_pkg::ADNH_RA_BIT];
    dec.arg8 = insn[15:8];
    // Immediate low byte follows the opcode, high byte comes last.
    dec.imm16 = insn[23:8];
    dec.mgr_ok = (dec.op == pdc_pkg::end_thread_op) || (dec.op == pdc_pkg::launch_channel_op) ||
                 (dec.op == pdc_pkg::no_operation_op) || (dec.op == pdc_pkg::send_event_op) ||
                 (dec.op == pdc_pkg::wait_event_op);
    // Channel threads take all but launch and undefined codes.
    dec.ch_ok = (dec.op != pdc_pkg::launch_channel_op) && (dec.op != pdc_pkg::undefined_op);
  end
endmodule

/* verification/pdc_periph_model.sv */
`timescale 1ns/1ps
module pdc_periph_model (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Lines the bench asks to raise.
  input wire logic [pdc_pkg::NUM_REQ-1:0] want,
  // Request levels toward the controller.
  output logic [pdc_pkg::NUM_REQ-1:0] periph_req
);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      periph_req <= '0;
    end else begin
      periph_req <= want;
    end
  end
endmodule

/* verification/pdc_top_tb_top.sv */
`timescale 1ns/1ps
module pdc_top_tb_top;
  logic core_clk;
  logic rst_b;
  pdc_pkg::pdc_apb_req_s req;
  pdc_pkg::pdc_apb_rsp_s rsp;
  logic [pdc_pkg::NUM_REQ-1:0] want;
  logic [pdc_pkg::NUM_REQ-1:0] periph_req;
  logic [15:0] irq;
  logic abort;
  logic [31:0] q;
  logic e;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  typedef struct packed {logic ra; logic [15:0] imm; logic [31:0] st; logic [31:0] ex;} pdc_row_s;
  pdc_row_s rows [4];
  pdc_top dut_u (.core_clk(core_clk), .rst_b(rst_b), .apb_req(req), .apb_rsp(rsp),
    .periph_req(periph_req), .irq(irq), .abort(abort));
  pdc_periph_model peer_u (.core_clk(core_clk), .rst_b(rst_b), .want(want),
    .periph_req(periph_req));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] ex);
    checks_done++;
    if (got !== ex) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do @(posedge core_clk); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] ex);
    apb(1'b0, a, 32'h0000_0000);
    chk(q & m, ex);
  endtask
  task automatic issue(input logic [3:0] t, input logic [31:0] w, input logic [31:0] imm);
    apb(1'b1, pdc_pkg::OFS_INSN_HI, imm);
    apb(1'b1, pdc_pkg::OFS_INSN_LO, w);
    apb(1'b1, pdc_pkg::OFS_ISSUE, {28'h000_0000, t});
  endtask
  task automatic irq_is(input logic [15:0] ex);
    repeat (3) @(posedge core_clk);
    chk({16'h0000, irq}, {16'h0000, ex});
  endtask
  initial begin
    rst_b = 1'b0;
    req = '0;
    want = '0;
    rows[0] = '{1'b0, 16'h0010, 32'h0000_0005, 32'hFFFF_0015};
    rows[1] = '{1'b1, 16'hFFF0, 32'h0000_1000, 32'h0000_0FF0};
    rows[2] = '{1'b0, 16'hFFFF, 32'h0000_0003, 32'h0000_0002};
    rows[3] = '{1'b1, 16'h0000, 32'h0000_0000, 32'hFFFF_0000};
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    chk({15'h0000, irq, abort}, 32'h0000_0000);
    issue(4'h8, 32'h0000_01A0, 32'h0000_0000);
    rdc(12'h108, 32'h0000_0007, 32'h0000_0001);
    foreach (rows[i]) begin
      issue(4'h1, {16'h0000, rows[i].ra ? pdc_pkg::MOV_DAR : pdc_pkg::MOV_SAR, pdc_pkg::ENC_MOV},
        rows[i].st);
      issue(4'h1, {8'h00, rows[i].imm, pdc_pkg::ENC_ADNH | {6'h00, rows[i].ra, 1'b0}},
        32'h0000_0000);
      rdc(12'h420 + {9'h000, rows[i].ra, 2'h0}, 32'hFFFF_FFFF, rows[i].ex);
    end
    issue(4'h1, {16'h0000, pdc_pkg::MOV_CCR, pdc_pkg::ENC_MOV}, 32'h0000_0100);
    rdc(12'h044, 32'h0000_000F, 32'h0000_0004);
    rdc(12'h428, 32'hFFFF_FFFF, 32'h0000_0000);
    issue(4'h1, {24'h00_0000, pdc_pkg::ENC_KILL}, 32'h0000_0000);
    issue(4'h8, 32'h0000_01A0, 32'h0000_0000);
    issue(4'h1, 32'h0000_02A0, 32'h0000_0000);
    rdc(12'h034, 32'h0000_0006, 32'h0000_0002);
    rdc(12'h044, 32'h0000_000F, 32'h0000_0001);
    issue(4'h1, {24'h00_0000, pdc_pkg::ENC_KILL}, 32'h0000_0000);
    issue(4'h8, {24'h00_0000, pdc_pkg::ENC_ADNH}, 32'h0000_0000);
    rdc(pdc_pkg::OFS_FSRD, 32'h0000_0001, 32'h0000_0001);
    apb(1'b1, pdc_pkg::OFS_FSRD, 32'h0000_0001);
    apb(1'b1, pdc_pkg::OFS_INTERRUPT_ENABLE_MASK, 32'h0000_0008);
    issue(4'h8, 32'h0000_0334, 32'h0000_0000);
    irq_is(16'h0008);
    repeat (20) @(posedge core_clk);
    irq_is(16'h0008);
    apb(1'b1, pdc_pkg::OFS_INTERRUPT_CLEAR_CONTROL, 32'h0000_0000);
    irq_is(16'h0008);
    apb(1'b1, pdc_pkg::OFS_INTERRUPT_CLEAR_CONTROL, 32'h0000_0008);
    irq_is(16'h0000);
    issue(4'h8, 32'h0000_0534, 32'h0000_0000);
    irq_is(16'h0000);
    rdc(pdc_pkg::OFS_EVENT_RIS, 32'h0000_0020, 32'h0000_0020);
    issue(4'h8, 32'h0000_01A0, 32'h0000_0000);
    issue(4'h1, 32'h0000_0430, 32'h0000_0000);
    rdc(12'h108, 32'h0000_0007, 32'h0000_0003);
    want <= 20'h0_0010;
    repeat (6) @(posedge core_clk);
    rdc(12'h108, 32'h0000_0007, 32'h0000_0001);
    // Halfword beats: aligned, odd offset, then an offset of eight.
    issue(4'h1, {16'h0000, pdc_pkg::MOV_CCR, pdc_pkg::ENC_MOV}, 32'h0000_0002);
    issue(4'h1, {16'h0000, pdc_pkg::MOV_DAR, pdc_pkg::ENC_MOV}, 32'h0000_0002);
    issue(4'h1, {24'h00_0000, pdc_pkg::ENC_LD}, 32'h0000_0000);
    rdc(12'h108, 32'h0000_0020, 32'h0000_0000);
    issue(4'h1, {16'h0000, pdc_pkg::MOV_DAR, pdc_pkg::ENC_MOV}, 32'h0000_0003);
    issue(4'h1, {24'h00_0000, pdc_pkg::ENC_LD}, 32'h0000_0000);
    rdc(12'h108, 32'h0000_0027, 32'h0000_0021);
    issue(4'h1, {16'h0000, pdc_pkg::MOV_DAR, pdc_pkg::ENC_MOV}, 32'h0000_000E);
    issue(4'h1, {24'h00_0000, pdc_pkg::ENC_LD}, 32'h0000_0000);
    rdc(12'h108, 32'h0000_0020, 32'h0000_0000);
    rdc(12'h420, 32'hFFFF_FFFF, 32'h0000_0008);
    apb(1'b0, 12'hFF0, 32'h0000_0000);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    issue(4'h8, 32'h0000_0334, 32'h0000_0000);
    irq_is(16'h0008);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({15'h0000, irq, abort}, 32'h0000_0000);
    rst_b <= 1'b1;
    rdc(pdc_pkg::OFS_INTERRUPT_ENABLE_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc(pdc_pkg::OFS_DSR, 32'h0000_000F, 32'h0000_0000);
    stop_test();
  end
endmodule
